// >>> verilog/psq_sequencer.sv
// front-panel sequencer: compare, illegal bit check, keypad buffer load
`timescale 1ns/1ns
module psq_sequencer
	import psq_pkg::*;
(
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              reset_n,
	// front panel
	input  wire logic              panelReset,
	input  wire logic              keyStrobe,
	input  wire logic [KEY_W-1:0]  keyCode,
	output logic      [31:0]       dispDigits,
	output logic      [7:0]        dispBlank,
	output logic                   writeLed,
	// profile module
	input  wire logic              profilePresent,
	input  wire logic              gangModule,
	input  wire logic              erasedHigh,
	input  wire logic [ADDR_W-1:0] copyLastAddr,
	// copy PROM socket
	output logic      [ADDR_W-1:0] promAddr,
	output logic                   promRead,
	output logic                   promWrite,
	input  wire logic [BUF_DW-1:0] promData
);
	localparam int SW = 4 + KEY_W + BUF_DW + ADDR_W;
	localparam logic [ADDR_W-1:0] BUF_LAST = ADDR_W'((1 << BUF_AW) - 1);

	psq_buf_if bufIf ();
	psq_buffer uBuf (.clk_sys(clk_sys), .bus(bufIf.mem));

	function automatic logic isHex(input logic [KEY_W-1:0] k);
		return k <= KEY_HEX_TOP;
	endfunction

	// erased-state mask from the profile; a bit is illegal if the PROM
	// already left the erased state where the buffer wants it erased
	function automatic logic illegalBits(input logic [7:0] p,
		input logic [7:0] b, input logic hi);
		logic [7:0] m;
		m = hi ? ERASED_ONES : ERASED_ZERO;
		return |((p ^ m) & ~(b ^ m));
	endfunction

	// all pins pass two flops; only stage two is read
	logic [SW-1:0] syncA_r, syncB_r;
	logic          keyPrev_r;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			syncA_r   <= '0;
			syncB_r   <= '0;
			keyPrev_r <= 1'b0;
		end else begin
			syncA_r   <= {panelReset, keyStrobe, profilePresent, gangModule,
				keyCode, promData, copyLastAddr};
			syncB_r   <= syncA_r;
			keyPrev_r <= syncB_r[SW-2];
		end
	end

	logic              pResetS, keyS, profS, gangS, keyHit;
	logic [KEY_W-1:0]  keyS_c;
	logic [7:0]        promS;
	logic [ADDR_W-1:0] lastS;
	logic              erasedS_r, erasedA_r;
	assign {pResetS, keyS, profS, gangS, keyS_c, promS, lastS} = syncB_r;
	assign keyHit = keyS & ~keyPrev_r;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			erasedA_r <= 1'b0;
			erasedS_r <= 1'b0;
		end else begin
			erasedA_r <= erasedHigh;
			erasedS_r <= erasedA_r;
		end
	end

	// sequencer state
	psq_state_type     state_r, state_nxt;
	psq_op_type        op_r, op_nxt;
	logic [31:0]       field_r, field_nxt;
	logic [ADDR_W-1:0] bufStart_r, bufStart_nxt;
	logic [ADDR_W-1:0] curProm_r, curProm_nxt;
	logic [ADDR_W-1:0] curBuf_r, curBuf_nxt;
	logic [7:0]        keyData_r, keyData_nxt;
	logic              keyed_r, keyed_nxt;
	logic              viewCopy_r, viewCopy_nxt;
	logic [7:0]        errProm_r, errProm_nxt;
	logic [7:0]        errBuf_r, errBuf_nxt;
	logic [4:0]        wait_r, wait_nxt;
	logic              bufWe;

	logic isEnter, isClear;
	assign isEnter = keyHit && keyS_c == KEY_ENTER;
	assign isClear = keyHit && keyS_c == KEY_CLEAR;

	always_comb begin
		logic failed;
		failed       = 1'b0;
		state_nxt    = state_r;
		op_nxt       = op_r;
		field_nxt    = field_r;
		bufStart_nxt = bufStart_r;
		curProm_nxt  = curProm_r;
		curBuf_nxt   = curBuf_r;
		keyData_nxt  = keyData_r;
		keyed_nxt    = keyed_r;
		viewCopy_nxt = viewCopy_r;
		errProm_nxt  = errProm_r;
		errBuf_nxt   = errBuf_r;
		wait_nxt     = wait_r;
		bufWe        = 1'b0;
		unique case (state_r)
			ST_IDLE, ST_GANG: begin
				if (keyHit && keyS_c == KEY_BLANK) begin
					if (gangS) begin
						state_nxt = ST_GANG;
					end else begin
						op_nxt    = OP_ILLEGAL_BIT;
						field_nxt = {ADDR_ZERO, lastS};
						bufStart_nxt = ADDR_ZERO;
						state_nxt = ST_FIELD;
					end
				end else if (keyHit && keyS_c == KEY_CMP) begin
					op_nxt    = OP_CMP;
					field_nxt = {ADDR_ZERO, lastS};
					bufStart_nxt = ADDR_ZERO;
					state_nxt = ST_FIELD;
				end else if (keyHit && keyS_c == KEY_PROGRAM) begin
					op_nxt    = OP_PROGRAM;
					field_nxt = {ADDR_ZERO, BUF_LAST};
					state_nxt = profS ? ST_FIELD : ST_WARN;
				end else if (state_r == ST_GANG && (isEnter || isClear)) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_WARN: begin
				// the warning is only advisory; any further go-ahead proceeds
				if (isEnter || (keyHit && keyS_c == KEY_PROGRAM)) begin
					state_nxt = ST_FIELD;
				end
			end
			ST_FIELD: begin
				if (keyHit && isHex(keyS_c)) begin
					field_nxt = {field_r[27:0], keyS_c[3:0]};
				end else if (isClear) begin
					field_nxt = '0;
				end else if (isEnter) begin
					if (op_r == OP_PROGRAM) begin
						curBuf_nxt = field_r[31:16];
						keyed_nxt  = 1'b0;
						keyData_nxt = '0;
						state_nxt  = ST_PROGRAM;
					end else begin
						state_nxt = ST_BSTART;
					end
				end
			end
			ST_BSTART: begin
				if (keyHit && isHex(keyS_c)) begin
					bufStart_nxt = {bufStart_r[11:0], keyS_c[3:0]};
				end else if (isClear) begin
					bufStart_nxt = ADDR_ZERO;
				end else if (isEnter) begin
					curProm_nxt = field_r[31:16];
					curBuf_nxt  = bufStart_r;
					state_nxt   = ST_RUN_ADDR;
				end
			end
			ST_RUN_ADDR: begin
				wait_nxt  = ACC_CNT;
				state_nxt = ST_RUN_WAIT;
			end
			ST_RUN_WAIT: begin
				if (wait_r == CNT_ZERO) begin
					state_nxt = ST_RUN_EVAL;
				end else begin
					wait_nxt = wait_r - 5'h01;
				end
			end
			ST_RUN_EVAL, ST_PAUSE: begin
				if (state_r == ST_RUN_EVAL) begin
					if (op_r == OP_CMP) begin
						failed = promS != bufIf.rdata;
					end else begin
						failed = illegalBits(promS, bufIf.rdata, erasedS_r);
					end
				end
				if (state_r == ST_PAUSE && keyHit && keyS_c == KEY_DIG_C) begin
					viewCopy_nxt = 1'b1;
				end else if (state_r == ST_PAUSE && keyHit &&
					keyS_c == KEY_DIG_B) begin
					viewCopy_nxt = 1'b0;
				end else if (state_r == ST_PAUSE && isClear) begin
					state_nxt = ST_DONE;
				end else if (failed) begin
					errProm_nxt  = promS;
					errBuf_nxt   = bufIf.rdata;
					viewCopy_nxt = 1'b0;
					state_nxt    = ST_PAUSE;
				end else if (state_r == ST_RUN_EVAL || isEnter) begin
					if (curProm_r == field_r[15:0]) begin
						state_nxt = ST_DONE;
					end else begin
						curProm_nxt = curProm_r + ADDR_ONE;
						curBuf_nxt  = curBuf_r + ADDR_ONE;
						state_nxt   = ST_RUN_ADDR;
					end
				end
			end
			ST_PROGRAM: begin
				if (keyHit && isHex(keyS_c)) begin
					keyData_nxt = {keyData_r[3:0], keyS_c[3:0]};
					keyed_nxt   = 1'b1;
				end else if (isClear) begin
					keyData_nxt = '0;
					keyed_nxt   = 1'b0;
				end else if (isEnter) begin
					bufWe       = keyed_r;
					keyed_nxt   = 1'b0;
					keyData_nxt = '0;
					if (curBuf_r == field_r[15:0]) begin
						state_nxt = ST_DONE;
					end else begin
						curBuf_nxt = curBuf_r + ADDR_ONE;
					end
				end
			end
			ST_DONE: begin
				if (isEnter) begin
					state_nxt = ST_FIELD;
				end
			end
		endcase
		if (pResetS) begin
			state_nxt = ST_IDLE;
		end
	end

	assign bufIf.addr  = curBuf_r[BUF_AW-1:0];
	assign bufIf.wdata = keyData_r;
	assign bufIf.we    = bufWe;

	// display and socket outputs, computed then registered
	logic [31:0]       disp_nxt;
	logic [7:0]        blank_nxt;
	logic [3:0]        opGlyph;
	logic              led_nxt, rd_nxt;
	logic [ADDR_W-1:0] pAddr_nxt;

	always_comb begin
		opGlyph   = (op_r == OP_CMP) ? GLY_C : GLY_B;
		disp_nxt  = '0;
		blank_nxt = BLANK_ALL;
		led_nxt   = 1'b0;
		rd_nxt    = 1'b0;
		pAddr_nxt = curProm_r;
		unique case (state_r)
			ST_IDLE: begin
				blank_nxt = BLANK_ALL;
			end
			ST_WARN: begin
				disp_nxt  = {GLY_E, GLY_4, 24'h000000};
				blank_nxt = BLANK_ERR;
			end
			ST_GANG: begin
				disp_nxt  = {GLY_E, GLY_0, 24'h000000};
				blank_nxt = BLANK_ERR;
			end
			ST_FIELD: begin
				disp_nxt  = field_r;
				blank_nxt = BLANK_NONE;
			end
			ST_BSTART: begin
				disp_nxt  = {bufStart_r, 16'h0000};
				blank_nxt = BLANK_BSTRT;
			end
			ST_RUN_ADDR, ST_RUN_WAIT, ST_RUN_EVAL: begin
				// read only; the socket write strobe is never raised
				rd_nxt    = 1'b1;
				disp_nxt  = {opGlyph, 16'h0000, GLY_A, GLY_A, GLY_A};
				blank_nxt = BLANK_CODE;
			end
			ST_PAUSE: begin
				disp_nxt  = viewCopy_r ? {curProm_r, 8'h00, errProm_r}
					: {curBuf_r, 8'h00, errBuf_r};
				// all four address digits stay lit; only the gap is dark
				blank_nxt = BLANK_ADDR;
			end
			ST_PROGRAM: begin
				led_nxt   = 1'b1;
				disp_nxt  = {curBuf_r, 8'h00, keyData_r};
				blank_nxt = keyed_r ? BLANK_ADDR : BLANK_BSTRT;
			end
			ST_DONE: begin
				if (op_r == OP_PROGRAM) begin
					disp_nxt  = {28'h0000000, GLY_F};
					blank_nxt = BLANK_F;
				end else begin
					disp_nxt  = {opGlyph, 24'h000000, GLY_F};
					blank_nxt = BLANK_FIN;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_r    <= ST_IDLE;
			op_r       <= OP_CMP;
			field_r    <= '0;
			bufStart_r <= ADDR_ZERO;
			curProm_r  <= ADDR_ZERO;
			curBuf_r   <= ADDR_ZERO;
			keyData_r  <= '0;
			keyed_r    <= 1'b0;
			viewCopy_r <= 1'b0;
			errProm_r  <= '0;
			errBuf_r   <= '0;
			wait_r     <= CNT_ZERO;
			dispDigits <= '0;
			dispBlank  <= BLANK_ALL;
			writeLed   <= 1'b0;
			promRead   <= 1'b0;
			promAddr   <= ADDR_ZERO;
		end else begin
			state_r    <= state_nxt;
			op_r       <= op_nxt;
			field_r    <= field_nxt;
			bufStart_r <= bufStart_nxt;
			curProm_r  <= curProm_nxt;
			curBuf_r   <= curBuf_nxt;
			keyData_r  <= keyData_nxt;
			keyed_r    <= keyed_nxt;
			viewCopy_r <= viewCopy_nxt;
			errProm_r  <= errProm_nxt;
			errBuf_r   <= errBuf_nxt;
			wait_r     <= wait_nxt;
			dispDigits <= disp_nxt;
			dispBlank  <= blank_nxt;
			writeLed   <= led_nxt;
			promRead   <= rd_nxt;
			promAddr   <= pAddr_nxt;
		end
	end

	assign promWrite = 1'b0;
endmodule

// >>> verilog/psq_pkg.sv
// shared constants and types for the front-panel operation sequencer
package psq_pkg;
	// buffer depth chosen at build time: 13 = 8Kx8, 14 = 16Kx8, 15 = 32Kx8
	localparam int BUF_AW_8K  = 13;
	localparam int BUF_AW_16K = 14;
	localparam int BUF_AW_32K = 15;
	localparam int BUF_AW     = BUF_AW_8K;
	localparam int BUF_DW     = 8;
	localparam int ADDR_W     = 16;
	localparam int KEY_W      = 5;

	// keypad codes: 00..0F are hex digits
	localparam logic [4:0] KEY_HEX_TOP = 5'h0F;
	localparam logic [4:0] KEY_ENTER   = 5'h10;
	localparam logic [4:0] KEY_CLEAR   = 5'h11;
	localparam logic [4:0] KEY_BLANK   = 5'h12;
	localparam logic [4:0] KEY_CMP     = 5'h13;
	localparam logic [4:0] KEY_PROGRAM = 5'h14;
	localparam logic [4:0] KEY_DIG_B   = 5'h0B;
	localparam logic [4:0] KEY_DIG_C   = 5'h0C;

	// display glyphs (hex digit values)
	localparam logic [3:0] GLY_A = 4'hA;
	localparam logic [3:0] GLY_B = 4'hB;
	localparam logic [3:0] GLY_C = 4'hC;
	localparam logic [3:0] GLY_E = 4'hE;
	localparam logic [3:0] GLY_F = 4'hF;
	localparam logic [3:0] GLY_0 = 4'h0;
	localparam logic [3:0] GLY_4 = 4'h4;
	localparam logic [7:0] BLANK_ALL   = 8'hFF;
	localparam logic [7:0] BLANK_NONE  = 8'h00;
	localparam logic [7:0] BLANK_CODE  = 8'h70;
	localparam logic [7:0] BLANK_FIN   = 8'h7E;
	localparam logic [7:0] BLANK_F     = 8'hFE;
	// error codes light only the two leftmost digits
	localparam logic [7:0] BLANK_ERR   = 8'h3F;
	localparam logic [7:0] BLANK_BSTRT = 8'hF0;
	localparam logic [7:0] BLANK_ADDR  = 8'h0C;

	localparam logic [15:0] ADDR_ZERO = 16'h0000;
	localparam logic [15:0] ADDR_ONE  = 16'h0001;
	localparam logic [7:0]  ERASED_ONES = 8'hFF;
	localparam logic [7:0]  ERASED_ZERO = 8'h00;

	// copy PROM read access, plus the two synchroniser stages on its data
	localparam int CLK_NS      = 40;
	localparam int PROM_ACC_NS = 450;
	localparam int SYNC_STAGES = 2;
	localparam int ACC_CYC = (PROM_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
	localparam logic [4:0] ACC_CNT = 5'(ACC_CYC);
	localparam logic [4:0] CNT_ZERO = 5'h00;

	typedef enum logic [1:0] {
		OP_CMP, OP_ILLEGAL_BIT, OP_PROGRAM
	} psq_op_type;
	typedef enum logic [3:0] {
		ST_IDLE, ST_WARN, ST_GANG, ST_FIELD, ST_BSTART, ST_RUN_ADDR,
		ST_RUN_WAIT, ST_RUN_EVAL, ST_PAUSE, ST_DONE, ST_PROGRAM
	} psq_state_type;
endpackage

// >>> verilog/psq_buf_if.sv
// carrier between the sequencer and its buffer memory
`timescale 1ns/1ns
interface psq_buf_if;
	import psq_pkg::*;
	logic [BUF_AW-1:0] addr;
	logic [BUF_DW-1:0] wdata;
	logic              we;
	logic [BUF_DW-1:0] rdata;
	modport ctl (output addr, output wdata, output we, input rdata);
	modport mem (input addr, input wdata, input we, output rdata);
endinterface

// >>> verilog/psq_buffer.sv
// byte-wide buffer memory; no reset so panel reset keeps its contents
`timescale 1ns/1ns
module psq_buffer
	import psq_pkg::*;
(
	// clock
	input wire logic clk_sys,
	// access
	psq_buf_if.mem   bus
);
	logic [BUF_DW-1:0] mem [0:(1<<BUF_AW)-1];
	logic [BUF_DW-1:0] rdata_r;

	always_ff @(posedge clk_sys) begin
		if (bus.we) begin
			mem[bus.addr] <= bus.wdata;
		end
		rdata_r <= mem[bus.addr];
	end
	assign bus.rdata = rdata_r;
endmodule

// >>> bench/psq_seq_props.sv
// port checker for the front-panel sequencer
`timescale 1ns/1ns
module psq_seq_props
	import psq_pkg::*;
(
	// clock and reset
	input wire logic              clk_sys,
	input wire logic              reset_n,
	// watched ports
	input wire logic              panelReset,
	input wire logic [7:0]        dispBlank,
	input wire logic              writeLed,
	input wire logic [ADDR_W-1:0] promAddr,
	input wire logic              promRead,
	input wire logic              promWrite
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	chk_never_writes: assert property (!promWrite)
		else $error("copy PROM write strobe raised");
	chk_start_idle: assert property ($rose(reset_n) |->
		dispBlank == BLANK_ALL && !writeLed) else $error("not idle");
	// two sync stages plus state and display registers
	chk_panel_idle: assert property (panelReset [*6] |->
		dispBlank == BLANK_ALL && !writeLed && !promRead)
		else $error("panel reset left sequencer busy");
	chk_addr_step: assert property (promRead && $past(promRead)
		&& promAddr != $past(promAddr) |->
		promAddr == $past(promAddr) + ADDR_ONE)
		else $error("copy address did not step by one");
	chk_addr_hold: assert property ($rose(promRead) |->
		##2 $stable(promAddr) [*8]) else $error("address moved in read");
	chk_run_code: assert property (promRead [*4] |->
		dispBlank == BLANK_CODE) else $error("no active code while reading");
	chk_done_quiet: assert property ($rose(dispBlank == BLANK_FIN)
		|-> !promRead) else $error("reads after finish");
	// keyed program data shows the same mask, but with the lamp already lit
	chk_pause_quiet: assert property ($rose(dispBlank == BLANK_ADDR)
		&& !$past(writeLed) |-> !promRead && !writeLed)
		else $error("reads during pause");
	chk_led_excl: assert property (writeLed |-> !promRead)
		else $error("write mode lit during copy read");

	cover property (dispBlank == BLANK_ADDR);
	cover property (dispBlank == BLANK_FIN);
	cover property (writeLed);
endmodule

bind psq_sequencer psq_seq_props chk (.clk_sys(clk_sys), .reset_n(reset_n),
	.panelReset(panelReset), .dispBlank(dispBlank), .writeLed(writeLed),
	.promAddr(promAddr), .promRead(promRead), .promWrite(promWrite));

// >>> bench/psq_prom_model.sv
// copy PROM in the socket: read only, slow access, fault injection
`timescale 1ns/1ns
module psq_prom_model
	import psq_pkg::*;
(
	// clock
	input wire logic              clk_sys,
	// socket
	input wire logic [ADDR_W-1:0] promAddr,
	input wire logic              promRead,
	output logic      [BUF_DW-1:0] promData,
	// faults commanded by the bench
	input wire logic [ADDR_W-1:0] flipAddr,
	input wire logic [BUF_DW-1:0] flipMask
);
	localparam int ACC = 12;
	logic [7:0]        img [0:3] = '{8'h5A, 8'h3C, 8'hF0, 8'h01};
	logic [ADDR_W-1:0] lastAddr = 16'h0000;
	int                age = 0;
	initial promData = 8'hA5;
	// until access time runs out data toggles, so an early sample shows
	always @(posedge clk_sys) begin
		if (!promRead || promAddr != lastAddr)
			age = 0;
		else if (age < ACC)
			age++;
		lastAddr = promAddr;
		if (age >= ACC)
			promData <= img[promAddr[1:0]]
				^ (promAddr == flipAddr ? flipMask : 8'h00);
		else
			promData <= ~promData;
	end
endmodule

// >>> bench/tb.sv
// self-checking bench for the front-panel sequencer
`timescale 1ns/1ns
module tb;
	import psq_pkg::*;
	typedef struct packed {
		logic [4:0]  key;
		logic [7:0]  blank;
		logic [31:0] dig;
		logic [31:0] mask;
		logic [1:0]  led;
	} psq_row_type;
	localparam logic [4:0]  K_E = KEY_ENTER;
	localparam logic [4:0]  K_NONE = 5'h1F;
	localparam logic [4:0]  K_RST = 5'h1E;
	localparam logic [7:0]  NOCHK = 8'h01;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	localparam logic [31:0] AD = 32'hFFFF0000;
	localparam logic [31:0] EV = 32'hFFFF00FF;
	localparam logic [31:0] FN = 32'hF000000F;
	localparam logic [15:0] BUF_LAST = 16'((1 << BUF_AW) - 1);
	// operation keys are only taken from idle or gang error, so a panel reset comes before each later one
	localparam psq_row_type ROWS [36] = '{
		'{KEY_PROGRAM,8'h00,{16'h0000,BUF_LAST},ALL,2'd0},
		'{KEY_CLEAR,8'h00,32'h0,ALL,2'd2},
		'{5'h03,8'h00,32'h3,ALL,2'd2},
		'{K_E,8'hF0,32'h0,AD,2'd1},
		'{5'h05,NOCHK,32'h0,32'h0,2'd1},
		'{5'h0A,8'h0C,32'h0000005A,32'h000000FF,2'd1},
		'{K_E,8'hF0,32'h00010000,AD,2'd1},
		'{5'h03,NOCHK,32'h0,32'h0,2'd1},
		'{5'h0C,NOCHK,32'h0,32'h0,2'd1},
		'{K_E,8'hF0,32'h00020000,AD,2'd1},
		'{5'h0F,NOCHK,32'h0,32'h0,2'd1},
		'{5'h00,NOCHK,32'h0,32'h0,2'd1},
		'{K_E,8'hF0,32'h00030000,AD,2'd1},
		'{5'h00,NOCHK,32'h0,32'h0,2'd1},
		'{5'h01,NOCHK,32'h0,32'h0,2'd1},
		'{K_E,8'hFE,32'hF,32'hF,2'd0},
		'{K_E,8'h00,32'h3,ALL,2'd0},
		'{K_RST,8'hFF,32'h0,32'h0,2'd0},
		'{KEY_CMP,8'h00,32'h3,ALL,2'd0},
		'{K_E,8'hF0,32'h0,AD,2'd0},
		'{K_E,8'h70,32'hC0000000,32'hF0000000,2'd0},
		'{K_NONE,8'h0C,32'h0001003C,EV,2'd0},
		'{KEY_DIG_C,8'h0C,32'h00010034,EV,2'd0},
		'{KEY_DIG_B,8'h0C,32'h0001003C,EV,2'd0},
		'{K_E,8'h7E,32'hC000000F,FN,2'd0},
		'{K_E,8'h00,32'h3,ALL,2'd0},
		'{K_E,8'hF0,32'h0,AD,2'd0},
		'{K_E,8'h0C,32'h0001003C,EV,2'd0},
		'{KEY_CLEAR,8'h7E,32'hC000000F,FN,2'd0},
		'{K_RST,8'hFF,32'h0,32'h0,2'd0},
		'{KEY_BLANK,8'h00,32'h3,ALL,2'd0},
		'{K_E,8'hF0,32'h0,AD,2'd0},
		'{K_E,8'h70,32'hB0000000,32'hF0000000,2'd0},
		'{K_NONE,8'h0C,32'h0001003C,EV,2'd0},
		'{KEY_DIG_C,8'h0C,32'h00010034,EV,2'd0},
		'{KEY_CLEAR,8'h7E,32'hB000000F,FN,2'd0}
	};
	logic              clk_sys, reset_n, panelReset, keyStrobe;
	logic [KEY_W-1:0]  keyCode;
	logic [31:0]       dispDigits;
	logic [7:0]        dispBlank;
	logic              writeLed, profilePresent, gangModule, erasedHigh;
	logic [ADDR_W-1:0] promAddr, flipAddr;
	logic              promRead, promWrite;
	logic [BUF_DW-1:0] promData, flipMask;
	int                n_errors = 0;
	int                compares = 0;

	psq_sequencer dut (.clk_sys(clk_sys), .reset_n(reset_n),
		.panelReset(panelReset), .keyStrobe(keyStrobe), .keyCode(keyCode),
		.dispDigits(dispDigits), .dispBlank(dispBlank), .writeLed(writeLed),
		.profilePresent(profilePresent), .gangModule(gangModule),
		.erasedHigh(erasedHigh), .copyLastAddr(16'h0003),
		.promAddr(promAddr), .promRead(promRead), .promWrite(promWrite),
		.promData(promData));
	psq_prom_model prom (.clk_sys(clk_sys), .promAddr(promAddr),
		.promRead(promRead), .promData(promData), .flipAddr(flipAddr),
		.flipMask(flipMask));

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic report_and_stop();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic cmp(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// key code settles three cycles ahead of the strobe for the sync stages
	task automatic press(input logic [4:0] k);
		keyCode <= k;
		repeat (3) @(posedge clk_sys);
		keyStrobe <= 1'b1;
		repeat (4) @(posedge clk_sys);
		keyStrobe <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask

	task automatic op(input psq_row_type r);
		int n;
		if (r.key == K_RST) begin
			panelReset <= 1'b1;
			repeat (8) @(posedge clk_sys);
			panelReset <= 1'b0;
		end else if (r.key != K_NONE)
			press(r.key);
		if (r.blank != NOCHK) begin
			n = 0;
			while (dispBlank !== r.blank && n < 400) begin
				@(posedge clk_sys);
				n++;
			end
			cmp("blank", {24'h0, r.blank}, {24'h0, dispBlank});
			cmp("digits", r.dig & r.mask, dispDigits & r.mask);
		end
		if (r.led != 2'd2)
			cmp("led", {31'h0, r.led[0]}, {31'h0, writeLed});
	endtask

	task automatic run2(input logic [7:0] b);
		press(K_E);
		press(K_E);
		op('{K_NONE, b, 32'h0, 32'h0, 2'd2});
	endtask

	initial begin
		int cyc;
		cyc = 0;
		forever begin
			@(posedge clk_sys);
			cyc++;
			if (cyc == 20000) begin
				n_errors++;
				report_and_stop();
			end
		end
	end

	initial begin
		reset_n = 1'b0;
		panelReset = 1'b0;
		keyStrobe = 1'b0;
		keyCode = 5'h00;
		profilePresent = 1'b1;
		gangModule = 1'b0;
		erasedHigh = 1'b1;
		flipAddr = 16'h0001;
		flipMask = 8'h08;
		repeat (6) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		cmp("idle blank", {24'h0, BLANK_ALL}, {24'h0, dispBlank});
		for (int i = 0; i < $size(ROWS); i++)
			op(ROWS[i]);
		op('{K_E, 8'h00, 32'h3, ALL, 2'd0});
		// copy byte only gains an erased bit: no failure with erased high
		flipAddr <= 16'h0002;
		flipMask <= 8'h01;
		run2(BLANK_FIN);
		erasedHigh <= 1'b0;
		press(K_E);
		run2(BLANK_ADDR);
		erasedHigh <= 1'b1;
		op('{K_RST, 8'hFF, 32'h0, 32'h0, 2'd0});
		gangModule <= 1'b1;
		op('{KEY_BLANK, 8'h3F, 32'hE0000000, 32'hFF000000, 2'd2});
		op('{K_E, BLANK_ALL, 32'h0, 32'h0, 2'd0});
		gangModule <= 1'b0;
		profilePresent <= 1'b0;
		op('{KEY_PROGRAM,8'h3F,32'hE4000000,32'hFF000000,2'd2});
		op('{K_E, 8'h00, {16'h0000, BUF_LAST}, ALL, 2'd0});
		op('{K_E, 8'hF0, 32'h0, AD, 2'd1});
		op('{K_E, 8'hF0, 32'h00010000, AD, 2'd1});
		profilePresent <= 1'b1;
		flipMask <= 8'h00;
		op('{K_RST, 8'hFF, 32'h0, 32'h0, 2'd0});
		// clean compare proves the skipped byte and the buffer survived
		press(KEY_CMP);
		run2(BLANK_FIN);
		report_and_stop();
	end
endmodule
